// >>> fei_top.sv
// Framer event interrupt logic with an AXI4-Lite register slave.
// Assumes framer inputs are asynchronous and held at least 3 cycles.
// How it works
// - Alignment change to a new position interrupts when enabled.
// - Framing bit error interrupts when enabled.
// - Bit error event depends on format: fbit, CRC-6, Ft, fbit or sync.
// - Two or more framing errors per superframe is severe errored framing.
// - Mimic assertion and deassertion interrupt when enabled.
// - Entry into and exit from inframe interrupt when enabled.
// - Reset clears all enable bits.
// - Alignment, fbit, bit error, severe flags set when event interrupted.
// - Mimic change flag sets when a mimic change interrupted.
// - Inframe change flag sets when an inframe change interrupted.
// - Live mimic and inframe state bits are readable.
// - Status read clears six flags and the interrupt, not live bits.
// - Enabled events drive the interrupt output.
// - Format from select bits: ESF, else 00 SF, 10 subscriber, x1 mux.
`timescale 1ns/1ps
`include "fei_defines.svh"
module fei_top
    import fei_pkg::*;
(
    // Clock and reset
    input wire logic SYS_CLK,
    input wire logic RESETN,
    // Framer indications, asynchronous
    input wire logic SF_START,
    input wire logic FBIT_ERR,
    input wire logic CRC_ERR,
    input wire logic FT_ERR,
    input wire logic SYNC_ERR,
    input wire logic ALIGN_NEW,
    input wire logic MIMIC_PRESENT,
    input wire logic INFRAME_STATE,
    // Framer interrupt, active low
    output logic IRQ_OUT_N,
    // Block interrupt, active high
    output logic IRQ,
    // Test speedup control
    output logic TEST_SPEEDUP,
    // AXI4-Lite write address
    input wire logic [`FEI_ADDR_W-1:0] AWADDR,
    input wire logic AWVALID,
    output logic AWREADY,
    // AXI4-Lite write data
    input wire logic [31:0] WDATA,
    input wire logic [3:0] WSTRB,
    input wire logic WVALID,
    output logic WREADY,
    // AXI4-Lite write response
    output logic [1:0] BRESP,
    output logic BVALID,
    input wire logic BREADY,
    // AXI4-Lite read address
    input wire logic [`FEI_ADDR_W-1:0] ARADDR,
    input wire logic ARVALID,
    output logic ARREADY,
    // AXI4-Lite read data
    output logic [31:0] RDATA,
    output logic [1:0] RRESP,
    output logic RVALID,
    input wire logic RREADY
);
    // ----------------------------------------------------------
    // Input synchronisers
    // ----------------------------------------------------------
    localparam int NIN = 8;
    logic [NIN-1:0] pin_in;
    logic [NIN-1:0] sync1_r;
    logic [NIN-1:0] sync2_r;
    logic [NIN-1:0] sync3_r;
    logic [NIN-1:0] live;
    logic [NIN-1:0] rise;

    assign pin_in = {INFRAME_STATE, MIMIC_PRESENT, ALIGN_NEW, SYNC_ERR,
                     FT_ERR, CRC_ERR, FBIT_ERR, SF_START};

    always_ff @(posedge SYS_CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            sync1_r <= '0;
            sync2_r <= '0;
            sync3_r <= '0;
        end
        else
        begin
            sync1_r <= pin_in;
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
        end
    end

    // Pulse inputs turn into one-cycle strobes; long pulses count once
    genvar gi;
    generate
        for (gi = 0; gi < NIN; gi = gi + 1)
        begin : g_edge
            assign rise[gi] = sync2_r[gi] & ~sync3_r[gi];
        end
    endgenerate
    assign live = sync2_r;

    // ----------------------------------------------------------
    // Registers
    // ----------------------------------------------------------
    logic [7:0] config_r;
    logic [7:0] enable_r;
    logic [`FEI_NEV-1:0] flag_r;
    logic [1:0] irq_stat_r;
    logic [1:0] irq_mask_r;
    fei_fmt_e fmt;
    logic [`FEI_NEV-1:0] events;
    logic [`FEI_NEV-1:0] hit;
    logic status_rd;

    always_comb
    begin
        if (config_r[`FEI_CFG_ESF])
            fmt = FMT_ESF;
        else if (config_r[`FEI_CFG_FMS_LO])
            fmt = FMT_DM;
        else if (config_r[`FEI_CFG_FMS_HI])
            fmt = FMT_SLC;
        else
            fmt = FMT_SF;
    end

    fei_event_gen u_evt (
        .clk(SYS_CLK),
        .rst_n(RESETN),
        .fmt(fmt),
        .sf_start(rise[0]),
        .fbit_err(rise[1]),
        .crc_err(rise[2]),
        .ft_err(rise[3]),
        .sync_err(rise[4]),
        .align_new(rise[5]),
        .mimic(live[6]),
        .inframe(live[7]),
        .events(events)
    );

    assign hit = events & enable_r[`FEI_NEV-1:0];

    // ----------------------------------------------------------
    // Bus slave
    // ----------------------------------------------------------
    fei_bus_e wst_r;
    fei_bus_e rst_r;
    logic aw_got_r;
    logic w_got_r;
    logic [`FEI_ADDR_W-1:0] awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic [31:0] rd_word;
    logic rd_ok;
    logic wr_ok;

    assign wr_ok = (awaddr_r == `FEI_OFS_CONFIG) ||
        (awaddr_r == `FEI_OFS_ENABLE) || (awaddr_r == `FEI_OFS_IRQ_STAT) ||
        (awaddr_r == `FEI_OFS_IRQ_MASK) || (awaddr_r == `FEI_OFS_STATUS);

    // Address and data may arrive in either order
    always_ff @(posedge SYS_CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            wst_r <= ST_IDLE;
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            awaddr_r <= '0;
            wdata_r <= '0;
            wstrb_r <= '0;
            AWREADY <= 1'b0;
            WREADY <= 1'b0;
            BVALID <= 1'b0;
            BRESP <= `FEI_RESP_OK;
        end
        else
        begin
            AWREADY <= 1'b0;
            WREADY <= 1'b0;
            case (wst_r)
                ST_IDLE:
                begin
                    if (AWVALID && !aw_got_r && !AWREADY)
                    begin
                        AWREADY <= 1'b1;
                        aw_got_r <= 1'b1;
                        awaddr_r <= AWADDR;
                    end
                    if (WVALID && !w_got_r && !WREADY)
                    begin
                        WREADY <= 1'b1;
                        w_got_r <= 1'b1;
                        wdata_r <= WDATA;
                        wstrb_r <= WSTRB;
                    end
                    if (aw_got_r && w_got_r)
                    begin
                        wst_r <= ST_RESP;
                        BVALID <= 1'b1;
                        BRESP <= wr_ok ? `FEI_RESP_OK : `FEI_RESP_SLVERR;
                    end
                end
                ST_RESP:
                begin
                    if (BREADY)
                    begin
                        BVALID <= 1'b0;
                        aw_got_r <= 1'b0;
                        w_got_r <= 1'b0;
                        wst_r <= ST_IDLE;
                    end
                end
                default: wst_r <= ST_IDLE;
            endcase
        end
    end

    logic wr_do;
    assign wr_do = (wst_r == ST_IDLE) && aw_got_r && w_got_r && wstrb_r[0];

    always_comb
    begin
        rd_ok = 1'b1;
        rd_word = 32'h0000_0000;
        case (ARADDR)
            `FEI_OFS_CONFIG: rd_word[7:0] = config_r;
            `FEI_OFS_ENABLE: rd_word[7:0] = enable_r;
            `FEI_OFS_STATUS:
                rd_word[7:0] = {flag_r, live[6], live[7]};
            `FEI_OFS_IRQ_STAT: rd_word[1:0] = irq_stat_r;
            `FEI_OFS_IRQ_MASK: rd_word[1:0] = irq_mask_r;
            default: rd_ok = 1'b0;
        endcase
    end

    assign status_rd = ARVALID && ARREADY && (ARADDR == `FEI_OFS_STATUS);

    always_ff @(posedge SYS_CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            rst_r <= ST_IDLE;
            ARREADY <= 1'b0;
            RVALID <= 1'b0;
            RDATA <= '0;
            RRESP <= `FEI_RESP_OK;
        end
        else
        begin
            case (rst_r)
                ST_IDLE:
                begin
                    ARREADY <= ARVALID && !ARREADY;
                    if (ARVALID && ARREADY)
                    begin
                        RDATA <= rd_word;
                        RRESP <= rd_ok ? `FEI_RESP_OK : `FEI_RESP_SLVERR;
                        RVALID <= 1'b1;
                        ARREADY <= 1'b0;
                        rst_r <= ST_RESP;
                    end
                end
                ST_RESP:
                begin
                    if (RREADY)
                    begin
                        RVALID <= 1'b0;
                        rst_r <= ST_IDLE;
                    end
                end
                default: rst_r <= ST_IDLE;
            endcase
        end
    end

    // ----------------------------------------------------------
    // Control and status state
    // ----------------------------------------------------------
    always_ff @(posedge SYS_CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            config_r <= `FEI_RST_CONFIG;
            enable_r <= `FEI_RST_ENABLE;
            irq_mask_r <= `FEI_RST_MASK;
        end
        else if (wr_do)
        begin
            if (awaddr_r == `FEI_OFS_CONFIG)
                config_r <= wdata_r[7:0];
            if (awaddr_r == `FEI_OFS_ENABLE)
                enable_r <= {1'b0, wdata_r[6:0]};
            if (awaddr_r == `FEI_OFS_IRQ_MASK)
                irq_mask_r <= wdata_r[1:0];
        end
    end

    // A read snapshot goes out with the clear; a same-cycle event survives
    always_ff @(posedge SYS_CLK or negedge RESETN)
    begin
        if (!RESETN)
            flag_r <= '0;
        else
            flag_r <= (status_rd ? '0 : flag_r) | hit;
    end

    // Bit 0: framer event set; bit 1: any framer flag cleared by read
    always_ff @(posedge SYS_CLK or negedge RESETN)
    begin
        if (!RESETN)
            irq_stat_r <= 2'h0;
        else
            irq_stat_r <= (irq_stat_r & ~((wr_do &&
                awaddr_r == `FEI_OFS_IRQ_STAT) ? wdata_r[1:0] : 2'h0))
                | {status_rd & (|flag_r), |hit};
    end

    always_ff @(posedge SYS_CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            IRQ_OUT_N <= 1'b1;
            IRQ <= 1'b0;
            TEST_SPEEDUP <= 1'b0;
        end
        else
        begin
            IRQ_OUT_N <= ~(|((status_rd ? '0 : flag_r) | hit));
            IRQ <= |(irq_stat_r & irq_mask_r);
            TEST_SPEEDUP <= enable_r[`FEI_EN_TEST];
        end
    end
endmodule

// >>> fei_defines.svh
// Constants for the framer event interrupt block.
// Assumes AXI4-Lite with 32-bit data, one register per aligned word.
`ifndef FEI_DEFINES_SVH
`define FEI_DEFINES_SVH
// --------------------------------------------------------------
// Register map: word indices; byte address is four times the index
// --------------------------------------------------------------
`define FEI_ADDR_W 8
`define FEI_IDX_CONFIG 8'h20
`define FEI_IDX_ENABLE 8'h21
`define FEI_IDX_STATUS 8'h22
`define FEI_IDX_IRQ_STAT 8'h23
`define FEI_IDX_IRQ_MASK 8'h24
`define FEI_OFS_CONFIG 8'h80
`define FEI_OFS_ENABLE 8'h84
`define FEI_OFS_STATUS 8'h88
`define FEI_OFS_IRQ_STAT 8'h8c
`define FEI_OFS_IRQ_MASK 8'h90
// --------------------------------------------------------------
// Field positions
// --------------------------------------------------------------
`define FEI_CFG_FMS_LO 2
`define FEI_CFG_FMS_HI 3
`define FEI_CFG_ESF 4
`define FEI_EN_TEST 6
`define FEI_NEV 6
`define FEI_ST_EVT_LSB 2
// --------------------------------------------------------------
// Reset values
// --------------------------------------------------------------
`define FEI_RST_CONFIG 8'h00
`define FEI_RST_ENABLE 8'h00
`define FEI_RST_MASK 2'h0
`define FEI_RESP_OK 2'h0
`define FEI_RESP_SLVERR 2'h2
`endif

// >>> fei_pkg.sv
// Types for the framer event interrupt block.
// Assumes fei_defines.svh is compiled alongside.
package fei_pkg;
    typedef enum logic [1:0] {FMT_SF, FMT_ESF, FMT_SLC, FMT_DM} fei_fmt_e;
    typedef enum {ST_IDLE, ST_RESP} fei_bus_e;
endpackage

// >>> fei_event_gen.sv
// Derives framer events from synchronised framer inputs.
// Assumes inputs already sampled into SYS_CLK; strobes are one cycle.
`timescale 1ns/1ps
`include "fei_defines.svh"
module fei_event_gen
    import fei_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Framer indications
    input wire fei_fmt_e fmt,
    input wire logic sf_start,
    input wire logic fbit_err,
    input wire logic crc_err,
    input wire logic ft_err,
    input wire logic sync_err,
    input wire logic align_new,
    input wire logic mimic,
    input wire logic inframe,
    // Event strobes
    output logic [`FEI_NEV-1:0] events
);
    logic [1:0] err_cnt_r;
    logic mimic_d_r;
    logic inframe_d_r;
    logic bee;
    logic sfe_hit;
    logic [1:0] inc;
    logic [1:0] sum;

    always_comb
    begin
        case (fmt)
            FMT_SF: bee = fbit_err;
            FMT_ESF: bee = crc_err;
            FMT_SLC: bee = ft_err;
            FMT_DM: bee = fbit_err | sync_err;
            default: bee = 1'b0;
        endcase
    end

    // Sync word errors add to the severe count only in multiplex format
    assign inc = {1'b0, fbit_err} +
        {1'b0, (fmt == FMT_DM) & sync_err};
    assign sum = (err_cnt_r > 2'd1) ? 2'd2 : err_cnt_r + inc;
    assign sfe_hit = (err_cnt_r < 2'd2) && (sum >= 2'd2);

    // Counter restarts each superframe; one event per superframe at most
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            err_cnt_r <= 2'd0;
        else if (sf_start)
            err_cnt_r <= 2'd0;
        else
            err_cnt_r <= (sum > 2'd2) ? 2'd2 : sum;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mimic_d_r <= 1'b0;
            inframe_d_r <= 1'b0;
        end
        else
        begin
            mimic_d_r <= mimic;
            inframe_d_r <= inframe;
        end
    end

    // Order: align, fbit, bee, sfe, mimic, inframe (msb first)
    assign events = {align_new,
                     fbit_err,
                     bee,
                     sfe_hit & ~sf_start,
                     mimic ^ mimic_d_r,
                     inframe ^ inframe_d_r};
endmodule

// >>> fei_sva.sv
// Checker for fei_top: bus answers, status clearing, framer interrupt.
// Assumes one clock domain and the bind at the foot of this file.
`timescale 1ns/1ps
`include "fei_defines.svh"
module fei_sva (
    // Clock and reset
    input wire logic SYS_CLK,
    input wire logic RESETN,
    // Framer indications
    input wire logic SF_START,
    input wire logic FBIT_ERR,
    input wire logic CRC_ERR,
    input wire logic FT_ERR,
    input wire logic SYNC_ERR,
    input wire logic ALIGN_NEW,
    input wire logic MIMIC_PRESENT,
    input wire logic INFRAME_STATE,
    // Outputs
    input wire logic IRQ_OUT_N,
    input wire logic TEST_SPEEDUP,
    // Bus
    input wire logic [`FEI_ADDR_W-1:0] ARADDR,
    input wire logic ARVALID,
    input wire logic ARREADY,
    input wire logic [31:0] RDATA,
    input wire logic [1:0] RRESP,
    input wire logic RVALID,
    input wire logic RREADY,
    input wire logic [1:0] BRESP,
    input wire logic BVALID,
    input wire logic BREADY
);
    logic [7:0] fin_now;
    logic [7:0] fin_r;
    logic [3:0] quiet_r;
    logic [7:0] rd_addr_r;
    logic rd_hs_r;
    logic rd_map;

    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (!RESETN);

    // ----
    // Helper logic
    // ----
    // Read-clear is only judged with no event still in the synchronisers
    assign fin_now = {INFRAME_STATE, MIMIC_PRESENT, ALIGN_NEW, SYNC_ERR,
                      FT_ERR, CRC_ERR, FBIT_ERR, SF_START};
    assign rd_map = rd_addr_r inside {`FEI_OFS_CONFIG, `FEI_OFS_ENABLE,
        `FEI_OFS_STATUS, `FEI_OFS_IRQ_STAT, `FEI_OFS_IRQ_MASK};
    always_ff @(posedge SYS_CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            fin_r <= 8'h00;
            quiet_r <= 4'h0;
        end
        else
        begin
            fin_r <= fin_now;
            if (fin_now != fin_r)
                quiet_r <= 4'h0;
            else if (quiet_r != 4'hf)
                quiet_r <= quiet_r + 4'h1;
        end
    end
    always_ff @(posedge SYS_CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            rd_addr_r <= 8'h00;
            rd_hs_r <= 1'b0;
        end
        else
        begin
            rd_hs_r <= ARVALID && ARREADY;
            if (ARVALID && ARREADY)
                rd_addr_r <= ARADDR;
        end
    end

    // ----
    // Assertions
    // ----
    AST_SPEEDUP_RST:
        assert property ($rose(RESETN) |-> !TEST_SPEEDUP [*4])
        else $error("test speedup set after reset");
    AST_RD_CLEAR:
        assert property (ARVALID && ARREADY && ARADDR == `FEI_OFS_STATUS
            && quiet_r >= 4'ha |-> ##[1:2] IRQ_OUT_N)
        else $error("status read left framer interrupt active");
    AST_IRQN_STICKY:
        assert property (!IRQ_OUT_N && !(ARVALID && ARREADY) && !rd_hs_r
            |=> !IRQ_OUT_N)
        else $error("framer interrupt dropped without a read");
    AST_IRQN_CAUSE:
        assert property ($fell(IRQ_OUT_N) |-> quiet_r < 4'ha)
        else $error("framer interrupt without input activity");
    AST_RD_LAT:
        assert property (ARVALID && ARREADY |=> RVALID)
        else $error("read answer late");
    AST_R_HOLD:
        assert property (RVALID && !RREADY
            |=> RVALID && $stable(RDATA) && $stable(RRESP))
        else $error("read answer not held");
    AST_B_HOLD:
        assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP))
        else $error("write answer not held");
    AST_RD_RESP:
        assert property (RVALID
            |-> RRESP == (rd_map ? `FEI_RESP_OK : `FEI_RESP_SLVERR))
        else $error("wrong read response code");
    AST_RD_UPPER:
        assert property (RVALID
            |-> RDATA[31:8] == 24'h0 && (rd_map || RDATA == 32'h0))
        else $error("read data outside byte lane");
endmodule

bind fei_top fei_sva u_fei_sva (
    .SYS_CLK(SYS_CLK), .RESETN(RESETN), .SF_START(SF_START),
    .FBIT_ERR(FBIT_ERR), .CRC_ERR(CRC_ERR), .FT_ERR(FT_ERR),
    .SYNC_ERR(SYNC_ERR), .ALIGN_NEW(ALIGN_NEW),
    .MIMIC_PRESENT(MIMIC_PRESENT), .INFRAME_STATE(INFRAME_STATE),
    .IRQ_OUT_N(IRQ_OUT_N), .TEST_SPEEDUP(TEST_SPEEDUP), .ARADDR(ARADDR),
    .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP),
    .RVALID(RVALID), .RREADY(RREADY), .BRESP(BRESP), .BVALID(BVALID),
    .BREADY(BREADY)
);

// >>> tb_framer_event_interrupts.sv
// Bench for fei_top: register tests over AXI4-Lite and an event table.
// Assumes fei_top and its bound checker; the bench drives all inputs.
`timescale 1ns/1ps
`include "fei_defines.svh"
module tb_framer_event_interrupts;
    // Step: enable, config, two framer inputs, expected status byte.
    // Inputs: 1 fbit, 2 crc, 3 ft, 4 sync, 5 align, 6 mimic, 7 inframe
    logic [31:0] steps [16] = '{
        32'h00005701, 32'h00007000, 32'h3f005080, 32'h3f001060,
        32'h3f002000, 32'h3f001170, 32'h3f102020, 32'h3f101150,
        32'h3f083020, 32'h3f044430, 32'h3f0c1060, 32'h08001120,
        32'h3f00600a, 32'h3f006008, 32'h3f007005, 32'h3f007705};
    logic sys_clk;
    logic resetn;
    logic [7:0] fin;
    logic irq_out_n, irq, test_speedup;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [3:0] wstrb;
    int fails;
    int n_checks;

    fei_top dut (
        .SYS_CLK(sys_clk), .RESETN(resetn), .SF_START(fin[0]),
        .FBIT_ERR(fin[1]), .CRC_ERR(fin[2]), .FT_ERR(fin[3]),
        .SYNC_ERR(fin[4]), .ALIGN_NEW(fin[5]), .MIMIC_PRESENT(fin[6]),
        .INFRAME_STATE(fin[7]), .IRQ_OUT_N(irq_out_n), .IRQ(irq),
        .TEST_SPEEDUP(test_speedup), .AWADDR(awaddr), .AWVALID(awvalid),
        .AWREADY(awready), .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid),
        .WREADY(wready), .BRESP(bresp), .BVALID(bvalid), .BREADY(bready),
        .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready),
        .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready)
    );

    initial
    begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    // ----
    // Tasks
    // ----
    task automatic give_verdict;
        $display("checks %0d, mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        n_checks++;
        if (s !== e)
        begin
            fails++;
            $display("wrong value at %0t: saw %h, expected %h", $time, s, e);
        end
    endtask

    // Every wait is bounded so a dead bus ends the run
    task automatic wt(ref logic s, inout int n);
        while (!s && n < 50)
        begin
            @(posedge sys_clk);
            n++;
        end
        if (n >= 50)
        begin
            fails++;
            $display("wrong value at %0t: bus timeout", $time);
            give_verdict();
        end
    endtask

    task automatic axw(input logic [7:0] a, input logic [31:0] d,
                       output logic [1:0] r);
        int n;
        bit ad;
        bit wd;
        n = 0;
        ad = 0;
        wd = 0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (!(ad && wd) && n < 50)
        begin
            @(posedge sys_clk);
            n++;
            ad = ad || awready;
            wd = wd || wready;
            awvalid <= !ad;
            wvalid <= !wd;
        end
        wt(bvalid, n);
        bready <= 1'b1;
        @(posedge sys_clk);
        r = bresp;
        bready <= 1'b0;
    endtask

    task automatic axr(input logic [7:0] a, output logic [31:0] d,
                       output logic [1:0] r);
        int n;
        n = 1;
        araddr <= a;
        arvalid <= 1'b1;
        @(posedge sys_clk);
        wt(arready, n);
        arvalid <= 1'b0;
        wt(rvalid, n);
        rready <= 1'b1;
        @(posedge sys_clk);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask

    // Pulses stay up 4 cycles so the input synchronisers see them
    task automatic ev(input int c);
        if (c > 5)
            fin[c] <= ~fin[c];
        else
        begin
            fin[c] <= 1'b1;
            repeat (4) @(posedge sys_clk);
            fin[c] <= 1'b0;
        end
        repeat (10) @(posedge sys_clk);
    endtask

    // ----
    // Main sequence
    // ----
    initial
    begin
        logic [31:0] s;
        logic [31:0] d;
        logic [1:0] r;
        fails = 0;
        n_checks = 0;
        resetn = 1'b0;
        fin = 8'h00;
        awaddr = 8'h00;
        araddr = 8'h00;
        wdata = 32'h0;
        wstrb = 4'hf;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        repeat (2) @(posedge sys_clk);
        resetn <= 1'b1;
        @(posedge sys_clk);
        for (int i = 0; i < 5; i++)
        begin
            axr(`FEI_OFS_IRQ_MASK - 8'(4 * i), d, r);
            chk(d, 32'h0);
        end
        chk(irq_out_n, 1'b1);
        $display("test reset done");
        axw(`FEI_OFS_ENABLE, 32'h40, r);
        chk(test_speedup, 1'b1);
        axr(`FEI_OFS_ENABLE, d, r);
        chk(d, 32'h40);
        axw(`FEI_OFS_ENABLE, 32'h0, r);
        chk(test_speedup, 1'b0);
        axr(8'h10, d, r);
        chk(d, 32'h0);
        chk(r, `FEI_RESP_SLVERR);
        axw(8'h14, 32'hff, r);
        chk(r, `FEI_RESP_SLVERR);
        wstrb <= 4'h0;
        axw(`FEI_OFS_ENABLE, 32'h3f, r);
        wstrb <= 4'hf;
        axr(`FEI_OFS_ENABLE, d, r);
        chk(d, 32'h0);
        $display("test access done");
        foreach (steps[i])
        begin
            s = steps[i];
            axw(`FEI_OFS_ENABLE, {24'h0, s[31:24]}, r);
            axw(`FEI_OFS_CONFIG, {24'h0, s[23:16]}, r);
            ev(0);
            if (s[15:12] != 4'h0)
                ev(s[15:12]);
            if (s[11:8] != 4'h0)
                ev(s[11:8]);
            chk(irq_out_n, s[7:2] == 6'h0);
            axr(`FEI_OFS_STATUS, d, r);
            chk(d, s[7:0]);
            chk(irq_out_n, 1'b1);
            axr(`FEI_OFS_STATUS, d, r);
            chk(d, s[1:0]);
        end
        $display("test events done");
        axw(`FEI_OFS_IRQ_MASK, 32'h0, r);
        chk(irq, 1'b0);
        axr(`FEI_OFS_IRQ_STAT, d, r);
        chk(d, 32'h3);
        axw(`FEI_OFS_IRQ_MASK, 32'h1, r);
        chk(irq, 1'b1);
        axw(`FEI_OFS_IRQ_STAT, 32'h1, r);
        chk(irq, 1'b0);
        axr(`FEI_OFS_IRQ_STAT, d, r);
        chk(d, 32'h2);
        axw(`FEI_OFS_IRQ_STAT, 32'h2, r);
        axr(`FEI_OFS_IRQ_STAT, d, r);
        chk(d, 32'h0);
        $display("test irq done");
        give_verdict();
    end
endmodule
